//--- core/plma_defines.svh
/*
  shared constants of the macrocell array: sizes, term map, bus offsets,
  field positions and reset values. assumes inclusion by bare name.
*/
`ifndef PLMA_DEFINES_SVH
`define PLMA_DEFINES_SVH

`define PLMA_NUM_OUT       10
`define PLMA_NUM_DIN       12
`define PLMA_NUM_ARR       22
`define PLMA_LIT_W         44
`define PLMA_TERM_W        45
`define PLMA_TERM_EN_BIT   44
`define PLMA_PAIRS         5
`define PLMA_PT_MIN        8
`define PLMA_PT_STEP       2
`define PLMA_SUM_TERMS     120
`define PLMA_OE_BASE       120
`define PLMA_SP_TERM       130
`define PLMA_AR_TERM       131
`define PLMA_NUM_TERMS     132

`define PLMA_ADDR_W        12
`define PLMA_DATA_W        32
`define PLMA_HI_W          13
`define PLMA_OFS_FUSE      12'h000
`define PLMA_OFS_FUSE_END  12'h420
`define PLMA_OFS_CFG       12'h800
`define PLMA_OFS_STAT      12'h804
`define PLMA_OFS_FB        12'h808

`define PLMA_CFG_W         20
`define PLMA_CFG_RST       20'h00000
`define PLMA_STAT_OE_POS   10
`define PLMA_STAT_Q_POS    20
`define PLMA_FUSE_RST      45'h0000_0000_0000

`endif

//--- core/plma_pkg.sv
/*
  types of the macrocell array: per-cell configuration, bus carriers,
  bus state and the term-count map. assumes plma_defines.svh beside it.
*/
`include "plma_defines.svh"

package plma_pkg;

  typedef struct packed {
    logic macrocell_type_select;
    logic macrocell_polarity_select;
  } plma_cell_cfg_s;

  typedef struct packed {
    logic [`PLMA_ADDR_W-1:0] address;
    logic                    read;
    logic                    write;
    logic [`PLMA_DATA_W-1:0] writedata;
  } plma_avs_req_s;

  typedef struct packed {
    logic [`PLMA_DATA_W-1:0] readdata;
    logic                    waitrequest;
  } plma_avs_rsp_s;

  typedef enum logic {
    PLMA_BUS_IDLE = 1'b0,
    PLMA_BUS_RESP = 1'b1
  } plma_bus_state_e;

  // sizes rise 8..16 over the first half and mirror back down
  function automatic int plma_pt_count(input int idx);
    int pos;
    pos = (idx < `PLMA_PAIRS) ? idx : (`PLMA_NUM_OUT - 1 - idx);
    return `PLMA_PT_MIN + `PLMA_PT_STEP * pos;
  endfunction : plma_pt_count

  function automatic int plma_pt_base(input int idx);
    int acc;
    acc = 0;
    for (int j = 0; j < idx; j++) begin
      acc = acc + plma_pt_count(j);
    end
    return acc;
  endfunction : plma_pt_base

endpackage : plma_pkg

//--- core/plma_pterm_sum.sv
/*
  sum of N product terms over the array literals.
  assumes fuse words come from registers held by the parent.
*/
`timescale 1ns/10ps
`include "plma_defines.svh"

module plma_pterm_sum #(
  parameter int N  = 8,
  parameter int LW = `PLMA_LIT_W,
  parameter int TW = `PLMA_TERM_W
) (
  // literals
  input  wire logic [LW-1:0]   lit_in,
  // fuse words, one per term
  input  wire logic [N*TW-1:0] fuse_in,
  // result
  output logic                 sum_out
);
  import plma_pkg::*;

  logic [N-1:0] term;

  genvar k;
  generate
    for (k = 0; k < N; k++) begin : g_term
      // an enabled term with no literal is constant true
      assign term[k] = fuse_in[k*TW+TW-1] &
                       (&(~fuse_in[k*TW +: LW] | lit_in));
    end
  endgenerate

  assign sum_out = |term;

endmodule : plma_pterm_sum

//--- core/plma_macrocell.sv
/*
  one output macrocell: register, type and polarity select, pin enable
  and array feedback. assumes terms are settled before each edge.
*/
`timescale 1ns/10ps
`include "plma_defines.svh"

module plma_macrocell (
  // clock and resets
  input  wire logic                   clk_in,
  input  wire logic                   pwr_rst_in,
  input  wire logic                   ar_term_in,
  // terms
  input  wire logic                   sp_term_in,
  input  wire logic                   sum_in,
  input  wire logic                   oe_term_in,
  input  wire plma_pkg::plma_cell_cfg_s cfg_in,
  // pin
  input  wire logic                   pin_in,
  output logic                        pin_out,
  output logic                        pin_oe_out,
  // array side
  output logic                        fb_out,
  output logic                        q_out
);
  import plma_pkg::*;

  logic q_ff;
  logic nxt_q;
  logic clr;
  logic drive_val;

  assign clr   = pwr_rst_in | ar_term_in;
  assign nxt_q = sp_term_in ? 1'b1 : sum_in;

  always_ff @(posedge clk_in or posedge clr) begin
    if (clr) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign drive_val  = cfg_in.macrocell_type_select ? sum_in : q_ff;
  assign pin_out    = cfg_in.macrocell_polarity_select ?
                      drive_val : ~drive_val;
  assign pin_oe_out = oe_term_in;
  // pin level is read back only while released
  assign fb_out     = cfg_in.macrocell_type_select ?
                      (oe_term_in ? pin_out : pin_in) : q_ff;
  assign q_out      = q_ff;

  a_reg_load: assert property (
    @(posedge clk_in) disable iff (pwr_rst_in | ar_term_in)
    !sp_term_in |=> q_ff == $past(sum_in))
    else $error("register did not load its sum");

  a_preset_one: assert property (
    @(posedge clk_in) disable iff (pwr_rst_in | ar_term_in)
    sp_term_in |=> q_ff)
    else $error("preset did not set the register");

  a_pol_sel: assert property (
    @(posedge clk_in) disable iff (pwr_rst_in)
    !cfg_in.macrocell_type_select |->
      pin_out == (q_ff ^ ~cfg_in.macrocell_polarity_select))
    else $error("registered pin polarity wrong");

  a_comb_path: assert property (
    @(posedge clk_in) disable iff (pwr_rst_in)
    cfg_in.macrocell_type_select |->
      pin_out == (sum_in ^ ~cfg_in.macrocell_polarity_select))
    else $error("combinatorial pin wrong");

  a_oe_release: assert property (
    @(posedge clk_in) disable iff (pwr_rst_in)
    !oe_term_in |-> !pin_oe_out)
    else $error("pin driven while enable term false");

  a_fb_reg: assert property (
    @(posedge clk_in) disable iff (pwr_rst_in)
    !cfg_in.macrocell_type_select |-> fb_out == q_ff)
    else $error("registered feedback wrong");

  a_fb_comb: assert property (
    @(posedge clk_in) disable iff (pwr_rst_in)
    (cfg_in.macrocell_type_select && !oe_term_in) |-> fb_out == pin_in)
    else $error("released pin not fed back");

endmodule : plma_macrocell

//--- core/plma_top.sv
/*
  sum-of-products array with ten output macrocells, fuse and cell
  configuration held in registers behind an avalon-mm slave.
  assumes dedicated inputs and pin levels synchronous to core_clk_in
  and a bench that resolves the pin wires from the enables.
*/
// Functional notes
// - ten outputs in five pairs with 8, 10, 12, 14, 16 terms each
// - each macrocell selectable registered or purely combinational
// - each output polarity selectable on its own, true or inverted
// - two config bits: upper 1 combinatorial, lower 1 active high
// - each pin enabled by its own term; released pin acts as input in combinatorial mode only
// - a pin may be driven always or switched by its enable term
// - registered mode feeds the register state back into the array
// - combinatorial mode feeds result, or pin level when disabled
// - one synchronous preset term sets registers at next clock edge
// - one asynchronous reset term clears registers at once
// - preset and reset terms shared and separate from sum terms
// - all registers cleared at power-up
`timescale 1ns/10ps
`include "plma_defines.svh"

module plma_top #(
  parameter int NUM_OUT = `PLMA_NUM_OUT,
  parameter int NUM_DIN = `PLMA_NUM_DIN
) (
  // clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    sys_rst_in,
  // dedicated inputs
  input  wire logic [NUM_DIN-1:0]      dat_in,
  // two-way pins
  input  wire logic [NUM_OUT-1:0]      io_in,
  output logic      [NUM_OUT-1:0]      io_out,
  output logic      [NUM_OUT-1:0]      io_oe_out,
  // register bus
  input  wire plma_pkg::plma_avs_req_s avs_req_in,
  output plma_pkg::plma_avs_rsp_s      avs_rsp_out
);
  import plma_pkg::*;

  localparam int LW = `PLMA_LIT_W;
  localparam int TW = `PLMA_TERM_W;
  localparam int NT = `PLMA_NUM_TERMS;
  localparam int AW = `PLMA_ADDR_W;
  localparam int DW = `PLMA_DATA_W;
  localparam int HW = `PLMA_HI_W;
  localparam int CW = `PLMA_CFG_W;

  // fuse store, configuration and bus state
  logic [TW-1:0]         fuse_ff [NT];
  logic [CW-1:0]         cfg_ff;
  logic [DW-1:0]         rdata_ff;
  logic [DW-1:0]         nxt_rdata;
  plma_bus_state_e       state_ff;
  plma_bus_state_e       nxt_state;

  // array nets
  logic [`PLMA_NUM_ARR-1:0] arr_sig;
  logic [LW-1:0]         lit;
  logic [NUM_OUT-1:0]    fb;
  logic [NUM_OUT-1:0]    q_all;
  logic [NUM_OUT-1:0]    sum_all;
  logic [NUM_OUT-1:0]    oe_all;
  logic                  sp_term;
  logic                  ar_term;

  // bus decode
  logic                  in_fuse;
  logic [7:0]            term_idx;
  logic                  hi_half;
  logic                  wr_ok;
  logic                  rd_take;
  logic                  waitreq;

  // twelve dedicated inputs plus ten pin feedbacks form the array
  assign arr_sig = {fb, dat_in};
  assign lit     = {~arr_sig, arr_sig};

  assign in_fuse  = (avs_req_in.address < `PLMA_OFS_FUSE_END);
  assign term_idx = avs_req_in.address[10:3];
  assign hi_half  = avs_req_in.address[2];

  // writes never wait; reads take one wait cycle for the data flop
  assign waitreq = avs_req_in.read && (state_ff == PLMA_BUS_IDLE);
  assign wr_ok   = avs_req_in.write && !avs_req_in.read;
  assign rd_take = avs_req_in.read && (state_ff == PLMA_BUS_IDLE);

  assign avs_rsp_out.waitrequest = waitreq;
  assign avs_rsp_out.readdata    = rdata_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PLMA_BUS_IDLE: begin
        if (rd_take) begin
          nxt_state = PLMA_BUS_RESP;
        end
      end
      PLMA_BUS_RESP: begin
        nxt_state = PLMA_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff <= PLMA_BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // unmapped reads return zero
  always_comb begin
    nxt_rdata = '0;
    if (in_fuse && (avs_req_in.address[1:0] == 2'h0)) begin
      if (term_idx < NT[7:0]) begin
        if (hi_half) begin
          nxt_rdata = {{(DW-HW){1'b0}}, fuse_ff[term_idx][TW-1:DW]};
        end else begin
          nxt_rdata = fuse_ff[term_idx][DW-1:0];
        end
      end
    end else if (avs_req_in.address == `PLMA_OFS_CFG) begin
      nxt_rdata = {{(DW-CW){1'b0}}, cfg_ff};
    end else if (avs_req_in.address == `PLMA_OFS_STAT) begin
      nxt_rdata = '0;
      nxt_rdata[NUM_OUT-1:0] = io_out;
      nxt_rdata[`PLMA_STAT_OE_POS +: NUM_OUT] = io_oe_out;
      nxt_rdata[`PLMA_STAT_Q_POS +: NUM_OUT]  = q_all;
    end else if (avs_req_in.address == `PLMA_OFS_FB) begin
      nxt_rdata = {{(DW-`PLMA_NUM_ARR){1'b0}}, arr_sig};
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_ff <= '0;
    end else if (rd_take) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_ff <= `PLMA_CFG_RST;
    end else if (wr_ok && (avs_req_in.address == `PLMA_OFS_CFG)) begin
      cfg_ff <= avs_req_in.writedata[CW-1:0];
    end
  end

  // fuses cleared at power-up leave every term false and every pin free
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int t = 0; t < NT; t++) begin
        fuse_ff[t] <= `PLMA_FUSE_RST;
      end
    end else if (wr_ok && in_fuse && (term_idx < NT[7:0]) &&
                 (avs_req_in.address[1:0] == 2'h0)) begin
      if (hi_half) begin
        fuse_ff[term_idx][TW-1:DW] <= avs_req_in.writedata[HW-1:0];
      end else begin
        fuse_ff[term_idx][DW-1:0]  <= avs_req_in.writedata;
      end
    end
  end

  // shared control terms, one each, outside the per-output sums
  plma_pterm_sum #(
    .N  (1),
    .LW (LW),
    .TW (TW)
  ) u_sp_term (
    .lit_in  (lit),
    .fuse_in (fuse_ff[`PLMA_SP_TERM]),
    .sum_out (sp_term)
  );

  plma_pterm_sum #(
    .N  (1),
    .LW (LW),
    .TW (TW)
  ) u_ar_term (
    .lit_in  (lit),
    .fuse_in (fuse_ff[`PLMA_AR_TERM]),
    .sum_out (ar_term)
  );

  genvar i;
  genvar k;
  generate
    for (i = 0; i < NUM_OUT; i++) begin : g_cell
      localparam int CNT  = plma_pt_count(i);
      localparam int BASE = plma_pt_base(i);
      logic [CNT*TW-1:0] sum_fuse;
      plma_cell_cfg_s    cell_cfg;

      for (k = 0; k < CNT; k++) begin : g_map
        assign sum_fuse[k*TW +: TW] = fuse_ff[BASE+k];
      end

      assign cell_cfg = cfg_ff[2*i +: 2];

      plma_pterm_sum #(
        .N  (CNT),
        .LW (LW),
        .TW (TW)
      ) u_sum (
        .lit_in  (lit),
        .fuse_in (sum_fuse),
        .sum_out (sum_all[i])
      );

      plma_pterm_sum #(
        .N  (1),
        .LW (LW),
        .TW (TW)
      ) u_oe (
        .lit_in  (lit),
        .fuse_in (fuse_ff[`PLMA_OE_BASE+i]),
        .sum_out (oe_all[i])
      );

      plma_macrocell u_cell (
        .clk_in     (core_clk_in),
        .pwr_rst_in (sys_rst_in),
        .ar_term_in (ar_term),
        .sp_term_in (sp_term),
        .sum_in     (sum_all[i]),
        .oe_term_in (oe_all[i]),
        .cfg_in     (cell_cfg),
        .pin_in     (io_in[i]),
        .pin_out    (io_out[i]),
        .pin_oe_out (io_oe_out[i]),
        .fb_out     (fb[i]),
        .q_out      (q_all[i])
      );
    end
  endgenerate

  sequence s_rd_req;
    avs_req_in.read && (state_ff == PLMA_BUS_IDLE);
  endsequence

  sequence s_rd_answer;
    avs_rsp_out.waitrequest ##1 !avs_rsp_out.waitrequest;
  endsequence

  sequence s_rd_at(logic [`PLMA_ADDR_W-1:0] adr);
    rd_take && (avs_req_in.address == adr);
  endsequence

  a_read_wait: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    s_rd_req |-> s_rd_answer)
    else $error("read not answered after one wait cycle");

  a_cfg_write: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (wr_ok && avs_req_in.address == `PLMA_OFS_CFG) |=>
      cfg_ff == $past(avs_req_in.writedata[CW-1:0]))
    else $error("configuration write lost");

  a_cfg_readback: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    s_rd_at(`PLMA_OFS_CFG) |=>
      avs_rsp_out.readdata == {{(DW-CW){1'b0}}, $past(cfg_ff)})
    else $error("configuration readback wrong");

  a_preset_all: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (sp_term && !ar_term) ##1 !ar_term |-> &q_all)
    else $error("preset did not set all registers");

  a_async_all: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    ar_term |-> (q_all == '0))
    else $error("reset term did not clear registers");

  a_power_clear: assert property (
    @(posedge core_clk_in)
    $fell(sys_rst_in) |-> (q_all == '0) && (io_oe_out == '0))
    else $error("registers not cleared after power-up");

  // bus answers and readback
  a_write_nowait: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (avs_req_in.write && !avs_req_in.read) |->
      !avs_rsp_out.waitrequest)
    else $error("write held in wait");

  a_rdata_hold: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !rd_take |=>
      avs_rsp_out.readdata == $past(avs_rsp_out.readdata))
    else $error("read data moved without a read");

  a_read_release: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (state_ff == PLMA_BUS_RESP) |=> (state_ff == PLMA_BUS_IDLE))
    else $error("bus stuck after answer");

  a_unmapped_zero: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (rd_take && !in_fuse &&
     (avs_req_in.address != `PLMA_OFS_CFG) &&
     (avs_req_in.address != `PLMA_OFS_STAT) &&
     (avs_req_in.address != `PLMA_OFS_FB)) |=>
      avs_rsp_out.readdata == '0)
    else $error("unmapped read not zero");

  a_cfg_hold: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !(wr_ok && (avs_req_in.address == `PLMA_OFS_CFG)) |=>
      cfg_ff == $past(cfg_ff))
    else $error("configuration changed without a write");

  // status and feedback words mirror pins, enables and registers
  a_stat_read: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    s_rd_at(`PLMA_OFS_STAT) |=>
      (avs_rsp_out.readdata[NUM_OUT-1:0] == $past(io_out)) &&
      (avs_rsp_out.readdata[`PLMA_STAT_OE_POS +: NUM_OUT] ==
       $past(io_oe_out)) &&
      (avs_rsp_out.readdata[`PLMA_STAT_Q_POS +: NUM_OUT] ==
       $past(q_all)))
    else $error("status word wrong");

  a_fb_read: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    s_rd_at(`PLMA_OFS_FB) |=>
      avs_rsp_out.readdata[`PLMA_NUM_ARR-1:0] == $past(arr_sig))
    else $error("feedback word wrong");

  // shared terms move only on writes that reach their own words
  a_ctl_fuse_hold: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !(wr_ok && in_fuse && (term_idx >= 8'(`PLMA_SP_TERM))) |=>
      (fuse_ff[`PLMA_SP_TERM] == $past(fuse_ff[`PLMA_SP_TERM])) &&
      (fuse_ff[`PLMA_AR_TERM] == $past(fuse_ff[`PLMA_AR_TERM])))
    else $error("shared control term changed without its write");

endmodule : plma_top

//--- tb/plma_board.sv
/*
  board model beside the array: resolves the ten two-way pins.
  assumes the bench chooses the level the board puts on released pins.
*/
`timescale 1ns/10ps

module plma_board (
  // clock
  input  wire logic       clk_in,
  // device side
  input  wire logic [9:0] drv_in,
  input  wire logic [9:0] oe_in,
  // board side
  input  wire logic [9:0] val_in,
  input  wire logic [9:0] en_in,
  // resolved pins
  output logic      [9:0] pin_out
);
  logic [9:0] last_ff = 10'h000;

  // board backs off while the cell drives, so no contention is modelled
  // an undriven pin shows the inverse of its last level, never a stale one
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (oe_in[i]) begin
        pin_out[i] = drv_in[i];
      end else if (en_in[i]) begin
        pin_out[i] = val_in[i];
      end else begin
        pin_out[i] = ~last_ff[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    last_ff <= pin_out;
  end
endmodule : plma_board

//--- tb/plma_top_bench.sv
/*
  bench for the macrocell array: avalon-mm tasks and directed scenarios.
  assumes the board model resolves the pins and the core sources beside.
*/
`timescale 1ns/10ps

`define CHK_EQ(got, exp) begin checked++; if ((got) !== (exp)) begin \
  errors++; $display("wrong value at %0t: got %h exp %h", $time, got, \
  exp); end end

module plma_top_bench;
  import plma_pkg::*;

  logic          core_clk_in = 1'b0;
  logic          sys_rst_in  = 1'b1;
  logic [11:0]   dat_in      = 12'h000;
  logic [9:0]    io_in;
  logic [9:0]    io_out;
  logic [9:0]    io_oe_out;
  logic [9:0]    brd_val     = 10'h000;
  logic [9:0]    brd_en      = 10'h3FF;
  plma_avs_req_s avs_req_in  = '0;
  plma_avs_rsp_s avs_rsp_out;
  int            errors      = 0;
  int            checked     = 0;
  int            cnt [10]    = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
  int            base;
  logic [31:0]   q;

  always #50 core_clk_in = ~core_clk_in;

  plma_top DUT (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .dat_in      (dat_in),
    .io_in       (io_in),
    .io_out      (io_out),
    .io_oe_out   (io_oe_out),
    .avs_req_in  (avs_req_in),
    .avs_rsp_out (avs_rsp_out)
  );

  plma_board board (
    .clk_in  (core_clk_in),
    .drv_in  (io_out),
    .oe_in   (io_oe_out),
    .val_in  (brd_val),
    .en_in   (brd_en),
    .pin_out (io_in)
  );

  task automatic report_and_stop();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // one transfer, held until waitrequest is seen low at a rising edge
  // values read right at the edge are the pre-edge ones: flops update later
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk_in);
    avs_req_in <= '{address: a, read: ~wr, write: wr, writedata: d};
    do begin
      @(posedge core_clk_in);
      n++;
      if (n > 20) begin
        errors++;
        report_and_stop();
      end
    end while (avs_rsp_out.waitrequest !== 1'b0);
    rd = avs_rsp_out.readdata;
    avs_req_in <= '0;
  endtask : bus

  task automatic term(input int t, input logic [43:0] m);
    bus(1'b1, 12'(8 * t), m[31:0], q);
    bus(1'b1, 12'(8 * t + 4), {19'h0, 1'b1, m[43:32]}, q);
  endtask : term

  task automatic drive(input logic [11:0] d);
    dat_in <= d;
    @(negedge core_clk_in);
  endtask : drive

  task automatic do_reset();
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
  endtask : do_reset

  initial begin
    do_reset();
    @(negedge core_clk_in);
    // power-up state: registers clear, active low, pins released
    `CHK_EQ(io_out, 10'h3FF)
    `CHK_EQ(io_oe_out, 10'h000)
    bus(1'b0, 12'h804, 32'h0, q);
    `CHK_EQ(q, 32'h000003FF)
    bus(1'b1, 12'h900, 32'h12345678, q);
    bus(1'b0, 12'h900, 32'h0, q);
    `CHK_EQ(q, 32'h00000000)

    // term boundaries: only the last term of each output is used
    bus(1'b1, 12'h800, 32'h000FFFFF, q);
    bus(1'b0, 12'h800, 32'h0, q);
    `CHK_EQ(q, 32'h000FFFFF)
    base = 0;
    for (int i = 0; i < 10; i++) begin
      term(120 + i, 44'h0);
      base = base + cnt[i];
      term(base - 1, 44'h1 << i);
    end
    drive(12'h000);
    `CHK_EQ(io_out, 10'h000)
    `CHK_EQ(io_oe_out, 10'h3FF)
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_in);
      drive(12'h001 << i);
      `CHK_EQ(io_out, 10'h001 << i)
    end
    @(posedge core_clk_in);
    bus(1'b1, 12'h800, 32'h000AAAAA, q);
    drive(12'h3FF);
    `CHK_EQ(io_out, 10'h000)
    @(posedge core_clk_in);
    drive(12'h2AA);
    `CHK_EQ(io_out, 10'h155)

    // registered toggle through feedback, then preset and async reset
    // inputs cleared first: bit 3 would hold the reset term true
    @(posedge core_clk_in);
    dat_in <= 12'h000;
    do_reset();
    bus(1'b1, 12'h800, 32'h00000001, q);
    term(120, 44'h0);
    term(0, 44'h4_0000_0000);
    term(130, 44'h004);
    term(131, 44'h008);
    @(negedge core_clk_in);
    q[0] = io_out[0];
    for (int k = 0; k < 3; k++) begin
      @(negedge core_clk_in);
      `CHK_EQ(io_out[0], ~q[0])
      q[0] = io_out[0];
    end
    @(posedge core_clk_in);
    drive(12'h004);
    `CHK_EQ(io_out[1], 1'b1)
    @(posedge core_clk_in);
    drive(12'h004);
    `CHK_EQ(io_out[1:0], 2'b01)
    @(posedge core_clk_in);
    drive(12'h00C);
    `CHK_EQ(io_out[1:0], 2'b10)
    @(posedge core_clk_in);
    drive(12'h00C);
    `CHK_EQ(io_out[1:0], 2'b10)
    @(posedge core_clk_in);
    dat_in <= 12'h000;

    // combinational feedback from a released pin, then from the cell
    do_reset();
    bus(1'b1, 12'h800, 32'h000000F0, q);
    term(122, 44'h010);
    term(123, 44'h0);
    term(18, 44'h0);
    term(30, 44'h4000);
    brd_val <= 10'h000;
    drive(12'h000);
    `CHK_EQ(io_oe_out[3:2], 2'b10)
    `CHK_EQ(io_out[3], 1'b0)
    @(posedge core_clk_in);
    brd_val <= 10'h004;
    drive(12'h000);
    `CHK_EQ(io_out[3], 1'b1)
    @(posedge core_clk_in);
    brd_val <= 10'h000;
    drive(12'h010);
    `CHK_EQ(io_oe_out[3:2], 2'b11)
    `CHK_EQ(io_out[3:2], 2'b11)
    // array word: cells 2 and 3 feed back high, dat_in bit 4 set
    bus(1'b0, 12'h808, 32'h0, q);
    `CHK_EQ(q, 32'h0000C010)
    report_and_stop();
  end
endmodule : plma_top_bench
